// [lieg_pkg.sv]
package lieg_pkg;

	// register byte offsets over the APB window
	localparam logic [7:0] OFS_SOURCE_ENABLES = 8'h00;
	localparam logic [7:0] OFS_OUTPUT_ENABLES = 8'h04;
	localparam logic [7:0] OFS_STATUS         = 8'h08;
	localparam logic [7:0] OFS_CLEAR          = 8'h0C;

	// field positions
	localparam int POS_DMA1       = 25;
	localparam int POS_DMA0       = 24;
	localparam int POS_LOCMON_HI  = 23;
	localparam int POS_LOCMON_LO  = 20;
	localparam int POS_MAILBOX_HI = 19;
	localparam int POS_MAILBOX_LO = 16;
	localparam int POS_HOST_ERR   = 13;
	localparam int POS_BP_ERR     = 12;
	localparam int POS_BP_EDGE    = 11;
	localparam int POS_ACK_CYCLE  = 10;
	localparam int POS_SYS_FAIL   = 9;
	localparam int POS_PWR_FAIL   = 8;
	localparam int POS_LEVEL_HI   = 7;
	localparam int POS_LEVEL_LO   = 1;

	// implemented bits; everything else is reserved and reads zero
	localparam logic [31:0] IMPL_MASK = 32'h03FF_3FFE;

	localparam logic [31:0] RST_SOURCE_ENABLES = 32'h0000_0000;
	localparam logic [31:0] RST_OUTPUT_ENABLES = 32'h0000_0000;
	localparam logic [31:0] RST_STATUS         = 32'h0000_0000;

	typedef struct packed {
		logic [1:0] dma;
		logic [3:0] locmon;
		logic [3:0] mailbox;
		logic       hostBusErr;
		logic       backplaneErr;
		logic       backplaneEdge;
		logic       ackCycle;
		logic       systemFail;
		logic       powerFail;
		logic [7:1] vmeLevel;
	} lieg_sources_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} lieg_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} lieg_apb_rsp_t;

endpackage

// [lieg_gate.sv]
`timescale 1ns/1ps
// Function
// (RQ1) enable bits 25 and 24 for DMA channels 1 and 0
// (RQ2) enable bits 23 down to 20 for location monitors 3..0
// (RQ3) enable bits 19 down to 16 for mailboxes 3..0
// (RQ4) host bus error enable bit 13, backplane error enable bit 12
// (RQ5) backplane edge enable bit 11, ack cycle enable bit 10
// (RQ6) system fail enable bit 9, power fail enable bit 8
// (RQ7) enabled source status follows its interrupt condition
// (RQ8) local interrupt only when source enabled and its output enable set
// (RQ9) software polls by enabling source, clearing output enable, reading status
// (RQ10) enable bits 7 down to 1 let status track backplane levels 7..1
// (RQ11) disabled source never sets status or interrupt; enables reset zero; reserved read zero
module lieg_gate
(
	input  wire logic                   clock,
	input  wire logic                   rstn,
	input  wire lieg_pkg::lieg_apb_req_t apbReq,
	output      lieg_pkg::lieg_apb_rsp_t apbRsp,
	input  wire lieg_pkg::lieg_sources_t sourcesAsync,
	output      logic                   localIrq
);
	import lieg_pkg::*;

	logic [31:0] interrupt_source_enables;
	logic [31:0] interrupt_output_enables;
	logic [31:0] irqStatus;
	logic [31:0] syncStage1;
	logic [31:0] syncStage2;
	logic [31:0] srcVec;
	logic [31:0] next_status;
	logic        wrAccess;
	logic        rdAccess;
	logic        mapped;
	logic [31:0] rdData;

	////////////////////////////////////////////////////////////////////////////
	// source mapping and synchronisers
	always_comb
	begin
		srcVec = 32'h0000_0000;
		srcVec[POS_DMA1:POS_DMA0] = sourcesAsync.dma;
		srcVec[POS_LOCMON_HI:POS_LOCMON_LO] = sourcesAsync.locmon;
		srcVec[POS_MAILBOX_HI:POS_MAILBOX_LO] = sourcesAsync.mailbox;
		srcVec[POS_HOST_ERR] = sourcesAsync.hostBusErr;
		srcVec[POS_BP_ERR] = sourcesAsync.backplaneErr;
		srcVec[POS_BP_EDGE] = sourcesAsync.backplaneEdge;
		srcVec[POS_ACK_CYCLE] = sourcesAsync.ackCycle;
		srcVec[POS_SYS_FAIL] = sourcesAsync.systemFail;
		srcVec[POS_PWR_FAIL] = sourcesAsync.powerFail;
		srcVec[POS_LEVEL_HI:POS_LEVEL_LO] = sourcesAsync.vmeLevel;
	end

	// sources come from other logic and from pins: always two flops
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			syncStage1 <= 32'h0000_0000;
			syncStage2 <= 32'h0000_0000;
		end
		else
		begin
			syncStage1 <= srcVec;
			syncStage2 <= syncStage1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb decode
	assign wrAccess = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign rdAccess = apbReq.psel && !apbReq.pwrite && !apbReq.penable;
	assign mapped = apbReq.paddr == OFS_SOURCE_ENABLES || apbReq.paddr == OFS_OUTPUT_ENABLES
		|| apbReq.paddr == OFS_STATUS || apbReq.paddr == OFS_CLEAR;

	////////////////////////////////////////////////////////////////////////////
	// enable registers
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			interrupt_source_enables <= RST_SOURCE_ENABLES;
		end
		// (RQ1) (RQ2) (RQ3) (RQ4) (RQ5) (RQ6) (RQ10) writable enables
		// (RQ11) reserved bits held zero
		else if (wrAccess && apbReq.paddr == OFS_SOURCE_ENABLES)
		begin
			interrupt_source_enables <= apbReq.pwdata & IMPL_MASK;
		end
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			interrupt_output_enables <= RST_OUTPUT_ENABLES;
		end
		else if (wrAccess && apbReq.paddr == OFS_OUTPUT_ENABLES)
		begin
			interrupt_output_enables <= apbReq.pwdata & IMPL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status: sticky while enabled, set wins over a same-cycle clear
	always_comb
	begin
		next_status = irqStatus;
		if (wrAccess && apbReq.paddr == OFS_CLEAR)
		begin
			next_status = next_status & ~apbReq.pwdata;
		end
		// (RQ7) (RQ10) enabled status tracks source
		next_status = next_status | (syncStage2 & interrupt_source_enables);
		// (RQ11) disabled source cannot hold status
		next_status = next_status & interrupt_source_enables & IMPL_MASK;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			irqStatus <= RST_STATUS;
		end
		else
		begin
			irqStatus <= next_status;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt output, registered
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			localIrq <= 1'b0;
		end
		// (RQ8) (RQ9) gate by output enables
		else
		begin
			localIrq <= |(next_status & interrupt_output_enables);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data; registered in setup so the access phase answers at once
	always_comb
	begin
		case (apbReq.paddr)
			OFS_SOURCE_ENABLES: rdData = interrupt_source_enables;
			OFS_OUTPUT_ENABLES: rdData = interrupt_output_enables;
			OFS_STATUS:         rdData = irqStatus;
			default:            rdData = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			apbRsp <= '0;
		end
		else
		begin
			apbRsp.pready <= apbReq.psel && !apbReq.penable;
			apbRsp.pslverr <= apbReq.psel && !apbReq.penable && !mapped;
			if (rdAccess)
			begin
				apbRsp.prdata <= rdData;
			end
		end
	end

endmodule

// [lieg_gate_props.sv]
`timescale 1ns/1ps
module lieg_gate_props
(
	input wire logic                    clock,
	input wire logic                    rstn,
	input wire lieg_pkg::lieg_apb_req_t apbReq,
	input wire lieg_pkg::lieg_apb_rsp_t apbRsp,
	input wire lieg_pkg::lieg_sources_t sourcesAsync,
	input wire logic                    localIrq
);
	import lieg_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	a_ready_timing: assert property (
		apbRsp.pready == $past(apbReq.psel && !apbReq.penable)) else $error("pready late");
	a_ready_once: assert property (apbRsp.pready |=> !apbRsp.pready)
		else $error("pready held");
	a_err_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
		else $error("stray pslverr");
	a_err_unmapped: assert property (
		apbRsp.pready && apbReq.paddr > 8'h0C |-> apbRsp.pslverr) else $error("no pslverr");
	a_reserved_zero: assert property ((apbRsp.prdata & ~IMPL_MASK) == 0)
		else $error("reserved set");
	a_rdata_hold: assert property (
		!(apbReq.psel && !apbReq.penable && !apbReq.pwrite) |=> $stable(apbRsp.prdata))
		else $error("prdata moved");
	a_irq_idle: assert property ($rose(rstn) |-> !localIrq)
		else $error("irq after reset");
	a_irq_cause: assert property ($rose(localIrq) |->
		$past(apbReq.pwrite) || $past(sourcesAsync != 0, 2)) else $error("irq uncaused");
endmodule
bind lieg_gate lieg_gate_props chk (.clock, .rstn, .apbReq, .apbRsp, .sourcesAsync, .localIrq);

// [lieg_host_model.sv]
`timescale 1ns/1ps
module lieg_host_model
(
	input  wire logic clock,
	input  wire logic localIrq,
	output logic      irqSeen
);
	always_ff @(posedge clock)
		irqSeen <= localIrq;
endmodule

// [test_local_interrupt_enable_gate.sv]
`timescale 1ns/1ps
module test_local_interrupt_enable_gate;
	import lieg_pkg::*;
	logic          clock;
	logic          rstn;
	lieg_apb_req_t req;
	lieg_apb_rsp_t apbRsp;
	lieg_sources_t src;
	logic          localIrq;
	logic          irqSeen;
	logic [32:0]   q[$];
	int            errors;
	int            comparisons;
	int            cycles;
	logic [31:0]   e;
	logic [31:0]   o;
	logic [31:0]   st;
	lieg_gate dut (.clock(clock), .rstn(rstn), .apbReq(req), .apbRsp(apbRsp),
		.sourcesAsync(src), .localIrq(localIrq));
	lieg_host_model host (.clock(clock), .localIrq(localIrq), .irqSeen(irqSeen));
	initial
	begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		if (errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// reads note their expected word; writes note nothing
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic r);
		@(posedge clock);
		if (!w)
			q.push_back({r, d});
		req <= '{1'h1, 1'h0, w, a, d};
		@(posedge clock);
		req.penable <= 1'h1;
		do @(posedge clock); while (apbRsp.pready !== 1'h1);
		req.psel <= 1'h0;
		req.penable <= 1'h0;
	endtask
	always @(posedge clock)
		if (apbRsp.pready === 1'h1 && req.psel === 1'h1 && req.penable === 1'h1
			&& req.pwrite === 1'h0)
			check({apbRsp.pslverr, apbRsp.prdata}, q.pop_front());
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			report_and_stop;
		end
	end
	initial
	begin
		rstn = 1'h0;
		req = '0;
		src = '0;
		void'($urandom(6524));
		repeat (3) @(posedge clock);
		rstn <= 1'h1;
		bus(0, OFS_SOURCE_ENABLES, RST_SOURCE_ENABLES, 0);
		bus(0, OFS_OUTPUT_ENABLES, RST_OUTPUT_ENABLES, 0);
		bus(0, OFS_STATUS, RST_STATUS, 0);
		bus(0, OFS_CLEAR, 0, 0);
		bus(1, 8'h10, '1, 1);
		bus(0, 8'h10, 0, 1);
		repeat (24)
		begin
			src <= lieg_sources_t'($urandom);
			e = $urandom;
			o = $urandom;
			bus(1, OFS_SOURCE_ENABLES, e, 0);
			bus(1, OFS_OUTPUT_ENABLES, o, 0);
			bus(0, OFS_SOURCE_ENABLES, e & IMPL_MASK, 0);
			bus(0, OFS_OUTPUT_ENABLES, o & IMPL_MASK, 0);
			st = {6'h00, src[22:13], 2'h0, src[12:7], src[6:0], 1'h0} & e;
			bus(1, OFS_STATUS, '1, 0);
			bus(0, OFS_STATUS, st, 0);
			check({32'h0, irqSeen}, {32'h0, |(st & o)});
			src <= '0;
			// let the synchroniser drain so clear is not overridden
			repeat (4) @(posedge clock);
			bus(1, OFS_CLEAR, '1, 0);
			bus(0, OFS_STATUS, 0, 0);
		end
		report_and_stop;
	end
endmodule
